// ===== hw/qcm_pkg.sv
// Register map, field layout and shared codes of the quad counter block.
package qcm_pkg;
    localparam int          ADDR_W        = 12;
    localparam logic [11:0] ADDR_CNT_A    = 12'h000;
    localparam logic [11:0] ADDR_CNT_B    = 12'h004;
    localparam logic [11:0] ADDR_CNT_C    = 12'h008;
    localparam logic [11:0] ADDR_CNT_D    = 12'h00c;
    localparam logic [11:0] ADDR_CLK_SEL  = 12'h010;
    localparam logic [11:0] ADDR_CFG_ONE  = 12'h014;
    localparam logic [11:0] ADDR_CFG_TWO  = 12'h018;
    localparam logic [11:0] ADDR_RUN      = 12'h01c;
    localparam logic [7:0]  REG_RESET     = 8'h00;
    localparam int          DIR_POS       = 4;
    localparam int          JOIN_LOW_POS  = 2;
    localparam int          JOIN_HIGH_POS = 3;
    localparam int          PULSE_POS     = 0;
    localparam int          CAP_POS       = 4;
    localparam int          RUN_POS       = 0;
    localparam int          HALVE_POS     = 4;
    localparam logic [1:0]  SRC_PIN       = 2'h0;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : qcm_pkg

// ===== hw/qcm_tick.sv
// Clock source selection, pin synchroniser and optional halving for one counter.
module qcm_tick
    import qcm_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [3:0] sources,
    input  wire logic [1:0] clock_source_code,
    input  wire logic       pin_clock_halve,
    input  wire logic       run,
    output logic            tick
);
    typedef struct packed {
        logic [3:0] meta;
        logic [3:0] sync;
        logic [3:0] prev;
        logic       half;
        logic       edge_q;
    } qcm_tick_state_t;

    qcm_tick_state_t s;
    qcm_tick_state_t next_s;
    logic [3:0]      rise;

    // Rising edges seen on the synchronised sources.
    assign rise = s.sync & ~s.prev;
    // A tick only counts while the counter runs, so a stopped counter ignores edges.
    assign tick = s.edge_q & run; // R06

    // Two flip-flops per source, then edge pick and optional halving of the pin clock.
    always_comb begin
        next_s        = s;
        next_s.meta   = sources;
        next_s.sync   = s.meta;
        next_s.prev   = s.sync;
        next_s.edge_q = 1'b0;
        if (run && rise[clock_source_code]) begin // R12
            if (clock_source_code == SRC_PIN && pin_clock_halve) begin
                next_s.half   = ~s.half; // R13
                next_s.edge_q = s.half;
            end else begin
                next_s.edge_q = 1'b1;
            end
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule : qcm_tick

// ===== hw/qcm_count8.sv
// One 8-bit up/down counting cell with a load port.
module qcm_count8
    import qcm_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       step,
    input  wire logic       up,
    input  wire logic       load,
    input  wire logic [7:0] load_value,
    output logic [7:0]      count
);
    typedef struct packed {
        logic [7:0] count;
    } qcm_count_state_t;

    qcm_count_state_t s;
    qcm_count_state_t next_s;

    assign count = s.count;

    // Load wins over a step; a step moves one count in the chosen direction.
    always_comb begin
        next_s = s;
        if (load) begin
            next_s.count = load_value;
        end else if (step) begin
            next_s.count = up ? 8'(s.count + 8'h01) : 8'(s.count - 8'h01); // R24
        end
    end

    // Count register with synchronous reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s.count <= REG_RESET;
        end else begin
            s <= next_s;
        end
    end
endmodule : qcm_count8

// ===== hw/qcm_quad_counter.sv
// Quad 8-bit counter control: register slave, modes, pair joining, capture and pulse outputs.
//
// How it works
// R01 - Each counter advances only while its own run bit is set.
// R02 - When a pair is joined, the lower run bit drives both; upper ignored.
// R03 - Reading a count register returns live count, or captured count in capture mode.
// R04 - Writing a count register sets its comparison value, not a readback value.
// R05 - Counts are readable anytime; internal sources always give a correct value.
// R06 - A stopped counter holds its content and ignores pin clock edges.
// R07 - Counter mode counting up: a write sets comparison and clears the count.
// R08 - Counter mode counting down: a write sets comparison and loads it.
// R09 - That clear or load waits for the counter's first enabled clock edge.
// R10 - In pulse or capture mode a write changes only the comparison value.
// R11 - Switching into counter mode neither clears nor loads the count.
// R12 - Each counter has a 2-bit source code; 00 picks its own port A pin.
// R13 - A per-counter bit halves the pin clock before counting.
// R14 - Software changes internal versus pin source only while the counter is stopped.
// R15 - Software changes pin halving only while stopped or on an internal source.
// R16 - Capture exists only on the first pair; any nonzero edge code enables it.
// R17 - Joined pairs: lower counter is the low byte and sets the direction.
// R18 - First pair without capture: interrupts per counter or joined; pulse users silent.
// R19 - First pair with capture: interrupts mark captures; pin 0 follows pulse enable.
// R20 - Second pair: per counter or joined interrupts; pin 1 follows pulse enable.
// R21 - Software changes modes only while the affected counters are stopped.
// R22 - Spurious interrupts may occur while capture is switched on or off.
// R23 - Software leaves one instruction between configuring and enabling.
// R24 - Direction bit: 0 counts down, 1 counts up.
// R25 - Counter mode: at target or zero, interrupt and reload on the next tick.
// R26 - Register effects reach counters only on their own synchronised ticks.
module qcm_quad_counter
    import qcm_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [3:0]        port_a_pins,
    input  wire logic              rc_or_external_clock,
    input  wire logic              rc_quarter_clock,
    input  wire logic              prescaled_32khz_clock,
    input  wire logic              prescaled_1khz_clock,
    input  wire logic              prescaled_128hz_clock,
    input  wire logic              capture_source,
    input  wire logic [1:0]        port_b_data,
    output logic                   port_b_pin_zero,
    output logic                   port_b_pin_one,
    output logic                   first_counter_irq,
    output logic                   second_counter_irq,
    output logic                   third_counter_irq,
    output logic                   fourth_counter_irq
);
    typedef struct packed {
        logic              aw_got;
        logic              w_got;
        logic [ADDR_W-1:0] awaddr;
        logic [7:0]        wdata;
        logic              wstb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic [3:0][7:0]   cmp;
        logic [7:0]        clk_sel;
        logic [7:0]        cfg_one;
        logic [7:0]        cfg_two;
        logic [7:0]        run_ctl;
        logic [3:0]        pending;
        logic [1:0][7:0]   shadow;
        logic [3:0]        irq;
        logic [1:0]        pwm_q;
        logic [1:0]        pin_q;
        logic              cap_meta;
        logic              cap_sync;
        logic              cap_prev;
    } qcm_state_t;

    qcm_state_t      s;
    qcm_state_t      next_s;
    logic [3:0][3:0] srcs;
    logic [3:0][7:0] cnt;
    logic [3:0][7:0] load_val;
    logic [3:0]      tick;
    logic [3:0]      en;
    logic [3:0]      up;
    logic [3:0]      cm;
    logic [3:0]      step;
    logic [3:0]      load;
    logic [1:0]      casc;
    logic [1:0]      pwm_on;
    logic            cap_on;
    logic            cap_ev;
    logic            wr_do;
    logic [15:0]     c16;
    logic [15:0]     m16;
    logic [7:0]      rd_cnt;

    // Mode bits decoded from the configuration registers.
    assign casc   = {s.cfg_one[JOIN_HIGH_POS], s.cfg_one[JOIN_LOW_POS]};
    assign pwm_on = s.cfg_one[PULSE_POS +: 2];
    assign cap_on = |s.cfg_two[CAP_POS +: 2]; // R16
    // Capture edge on the synchronised capture signal, filtered by the edge code.
    assign cap_ev = cap_on && ((s.cfg_two[CAP_POS] && s.cap_sync && !s.cap_prev)
                  || (s.cfg_two[CAP_POS + 1] && !s.cap_sync && s.cap_prev)); // R19
    assign wr_do  = s.aw_got && s.w_got && !s.bvalid;

    // Bus handshake outputs and registered answers.
    assign s_axi_awready      = !s.aw_got && !s.bvalid;
    assign s_axi_wready       = !s.w_got && !s.bvalid;
    assign s_axi_bvalid       = s.bvalid;
    assign s_axi_bresp        = s.bresp;
    assign s_axi_arready      = !s.rvalid;
    assign s_axi_rvalid       = s.rvalid;
    assign s_axi_rdata        = s.rdata;
    assign s_axi_rresp        = s.rresp;
    assign port_b_pin_zero    = s.pin_q[0];
    assign port_b_pin_one     = s.pin_q[1];
    assign first_counter_irq  = s.irq[0];
    assign second_counter_irq = s.irq[1];
    assign third_counter_irq  = s.irq[2];
    assign fourth_counter_irq = s.irq[3];

    // Per counter: run and direction routing, mode, source mux, tick and count cell.
    for (genvar i = 0; i < 4; i++) begin : g_cnt
        localparam int P  = i / 2;
        localparam bit HI = (i % 2) == 1;
        assign en[i] = (HI && casc[P]) ? s.run_ctl[RUN_POS + 2 * P] : s.run_ctl[RUN_POS + i]; // R01 R02
        assign up[i] = (HI && casc[P]) ? s.cfg_one[DIR_POS + 2 * P] : s.cfg_one[DIR_POS + i]; // R17 R24
        assign cm[i] = !(pwm_on[P] && (!HI || casc[P])) && !(cap_on && P == 0);
        assign load_val[i] = up[i] ? 8'h00 : s.cmp[i]; // R07 R08
        if (P == 0) begin : g_src_low
            assign srcs[i] = {prescaled_128hz_clock, rc_quarter_clock, rc_or_external_clock, port_a_pins[i]};
        end else begin : g_src_high
            assign srcs[i] = {prescaled_128hz_clock, prescaled_1khz_clock, prescaled_32khz_clock, port_a_pins[i]};
        end
        qcm_tick u_tick (
            .aclk              (aclk),
            .aresetn           (aresetn),
            .sources           (srcs[i]),
            .clock_source_code (s.clk_sel[2 * i +: 2]),
            .pin_clock_halve   (s.run_ctl[HALVE_POS + i]),
            .run               (en[i]),
            .tick              (tick[i])
        );
        qcm_count8 u_count (
            .aclk       (aclk),
            .aresetn    (aresetn),
            .step       (step[i]),
            .up         (up[i]),
            .load       (load[i]),
            .load_value (load_val[i]),
            .count      (cnt[i])
        );
    end

    // Counting control, capture, pulse outputs and the register slave.
    always_comb begin
        next_s          = s;
        step            = '0;
        load            = '0;
        c16             = 16'h0000;
        m16             = 16'h0000;
        rd_cnt          = 8'h00;
        next_s.irq      = '0;
        next_s.cap_meta = capture_source;
        next_s.cap_sync = s.cap_meta;
        next_s.cap_prev = s.cap_sync;
        for (int p = 0; p < 2; p++) begin
            if (casc[p]) begin
                c16 = {cnt[2 * p + 1], cnt[2 * p]};
                m16 = {s.cmp[2 * p + 1], s.cmp[2 * p]};
                if (tick[2 * p]) begin
                    if (s.pending[2 * p] || s.pending[2 * p + 1]) begin
                        load[2 * p]                = 1'b1; // R09 R26
                        load[2 * p + 1]            = 1'b1;
                        next_s.pending[2 * p +: 2] = 2'b00;
                    end else if (cm[2 * p] && (up[2 * p] ? (c16 == m16) : (c16 == 16'h0000))) begin
                        load[2 * p]       = 1'b1; // R25
                        load[2 * p + 1]   = 1'b1;
                        next_s.irq[2 * p] = 1'b1; // R18 R20
                    end else begin
                        step[2 * p]     = 1'b1;
                        step[2 * p + 1] = up[2 * p] ? (cnt[2 * p] == 8'hff) : (cnt[2 * p] == 8'h00); // R17
                    end
                    next_s.pwm_q[p] = c16 <= m16;
                end
            end else begin
                for (int k = 2 * p; k < 2 * p + 2; k++) begin
                    if (tick[k]) begin
                        if (s.pending[k]) begin
                            load[k]           = 1'b1; // R09 R26
                            next_s.pending[k] = 1'b0;
                        end else if (cm[k] && (up[k] ? (cnt[k] == s.cmp[k]) : (cnt[k] == 8'h00))) begin
                            load[k]       = 1'b1; // R25
                            next_s.irq[k] = 1'b1; // R18 R20
                        end else begin
                            step[k] = 1'b1; // R01
                        end
                    end
                end
                if (tick[2 * p]) begin
                    next_s.pwm_q[p] = cnt[2 * p] <= s.cmp[2 * p];
                end
            end
            // The pin carries the sampled pulse only while its pulse output is on.
            next_s.pin_q[p] = pwm_on[p] ? s.pwm_q[p] : port_b_data[p]; // R18 R19 R20
        end
        // A capture copies both first pair counts and flags both interrupts.
        if (cap_ev) begin
            next_s.shadow[0] = cnt[0]; // R19 R22
            next_s.shadow[1] = cnt[1];
            next_s.irq[1:0]  = 2'b11;
        end
        // Write address and data are taken in either order, then answered.
        if (s_axi_awvalid && s_axi_awready) begin
            next_s.aw_got = 1'b1;
            next_s.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_s.w_got = 1'b1;
            next_s.wdata = s_axi_wdata[7:0];
            next_s.wstb  = s_axi_wstrb[0];
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        if (wr_do) begin
            next_s.aw_got = 1'b0;
            next_s.w_got  = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = RESP_OKAY;
            case (s.awaddr)
                ADDR_CNT_A, ADDR_CNT_B, ADDR_CNT_C, ADDR_CNT_D: begin
                    if (s.wstb) begin
                        next_s.cmp[s.awaddr[3:2]] = s.wdata; // R04 R10
                        if (cm[s.awaddr[3:2]]) begin
                            next_s.pending[s.awaddr[3:2]] = 1'b1; // R07 R08
                        end
                    end
                end
                ADDR_CLK_SEL: begin
                    if (s.wstb) begin
                        next_s.clk_sel = s.wdata;
                    end
                end
                ADDR_CFG_ONE: begin
                    if (s.wstb) begin
                        next_s.cfg_one = s.wdata; // R11
                    end
                end
                ADDR_CFG_TWO: begin
                    if (s.wstb) begin
                        next_s.cfg_two = s.wdata;
                    end
                end
                ADDR_RUN: begin
                    if (s.wstb) begin
                        next_s.run_ctl = s.wdata;
                    end
                end
                default: begin
                    next_s.bresp = RESP_SLVERR;
                end
            endcase
        end
        // Reads answer one cycle after the address is taken.
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        rd_cnt = (cap_on && !s_axi_araddr[3]) ? s.shadow[s_axi_araddr[2]] : cnt[s_axi_araddr[3:2]]; // R03 R05
        if (s_axi_arvalid && s_axi_arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = RESP_OKAY;
            case (s_axi_araddr)
                ADDR_CNT_A, ADDR_CNT_B, ADDR_CNT_C, ADDR_CNT_D: next_s.rdata = {24'h000000, rd_cnt};
                ADDR_CLK_SEL: next_s.rdata = {24'h000000, s.clk_sel};
                ADDR_CFG_ONE: next_s.rdata = {24'h000000, s.cfg_one};
                ADDR_CFG_TWO: next_s.rdata = {24'h000000, s.cfg_two};
                ADDR_RUN:     next_s.rdata = {24'h000000, s.run_ctl};
                default: begin
                    next_s.rdata = 32'h00000000;
                    next_s.rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Checks on the counting, register and interrupt behaviour.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_plain_tick_a;
        tick[0] && !casc[0];
    endsequence

    sequence s_write_d;
        wr_do && s.wstb && s.awaddr == ADDR_CNT_D;
    endsequence

    property p_frozen_a;
        !en[0] |=> $stable(cnt[0]);
    endproperty
    a_frozen_a: assert property (p_frozen_a) else $error("Stopped counter changed."); // R01

    property p_join_gate;
        casc[0] && !s.run_ctl[RUN_POS] |=> $stable(cnt[1]);
    endproperty
    a_join_gate: assert property (p_join_gate) else $error("Joined upper counter ran."); // R02

    property p_read_c;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_CNT_C
            |=> s_axi_rvalid && s_axi_rdata == {24'h000000, $past(cnt[2])};
    endproperty
    a_read_c: assert property (p_read_c) else $error("Count read wrong."); // R03

    property p_write_d;
        s_write_d |=> s.cmp[3] == $past(s.wdata) && s_axi_bvalid;
    endproperty
    a_write_d: assert property (p_write_d) else $error("Comparison not written."); // R04

    property p_clear_up;
        s_plain_tick_a ##0 (s.pending[0] && up[0]) |=> cnt[0] == 8'h00 && !s.pending[0];
    endproperty
    a_clear_up: assert property (p_clear_up) else $error("Deferred clear missing."); // R07

    property p_load_down;
        s_plain_tick_a ##0 (s.pending[0] && !up[0]) |=> cnt[0] == $past(s.cmp[0]);
    endproperty
    a_load_down: assert property (p_load_down) else $error("Deferred load missing."); // R08

    property p_no_pending;
        wr_do && s.wstb && s.awaddr == ADDR_CNT_C && !cm[2] && !s.pending[2] |=> !s.pending[2];
    endproperty
    a_no_pending: assert property (p_no_pending) else $error("Pulse mode write touched count."); // R10

    property p_target_up;
        s_plain_tick_a ##0 (!s.pending[0] && cm[0] && up[0] && cnt[0] == s.cmp[0])
            |=> s.irq[0] && cnt[0] == 8'h00;
    endproperty
    a_target_up: assert property (p_target_up) else $error("Target reload missing."); // R25

    property p_pulse_quiet;
        $past(pwm_on[0]) && !$past(cap_on) |-> !s.irq[0];
    endproperty
    a_pulse_quiet: assert property (p_pulse_quiet) else $error("Pulse counter raised interrupt."); // R18

    property p_capture;
        cap_ev |=> s.irq[0] && s.irq[1] && s.shadow[0] == $past(cnt[0]);
    endproperty
    a_capture: assert property (p_capture) else $error("Capture not signalled."); // R19

    property p_high_join;
        $past(casc[1]) |-> !s.irq[3];
    endproperty
    a_high_join: assert property (p_high_join) else $error("Joined upper counter raised interrupt."); // R20
endmodule : qcm_quad_counter

// ===== tb/test_qcm_quad_counter.sv
// Self-checking bench for the quad counter control block.
module test_qcm_quad_counter
    import qcm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, pb0, pb1, cap;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [1:0]  bresp, rresp, r, pbd;
    logic [3:0]  pins, irq;
    logic [4:0]  src;
    int          err_total, check_count, irq_n[4];

    qcm_quad_counter i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port_a_pins(pins),
        .rc_or_external_clock(src[0]), .rc_quarter_clock(src[1]), .prescaled_32khz_clock(src[2]),
        .prescaled_1khz_clock(src[3]), .prescaled_128hz_clock(src[4]), .capture_source(cap),
        .port_b_data(pbd), .port_b_pin_zero(pb0), .port_b_pin_one(pb1), .first_counter_irq(irq[0]),
        .second_counter_irq(irq[1]), .third_counter_irq(irq[2]), .fourth_counter_irq(irq[3]));

    // Free-running 40 MHz clock.
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    // Counts interrupt pulses per counter.
    always @(posedge aclk) begin
        foreach (irq[i]) if (irq[i] === 1'b1) irq_n[i]++;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    // Compares one value and reports a mismatch.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One AXI4-Lite write; the response code lands in r.
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic ah;
        logic dh;
        ah = 1'b1;
        dh = 1'b1;
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (!ah && !dh && bvalid) begin
                r = bresp;
                bready <= 1'b0;
                @(posedge aclk);
                return;
            end
            if (ah && awready) begin
                ah = 1'b0;
                awvalid <= 1'b0;
            end
            if (dh && wready) begin
                dh = 1'b0;
                wvalid <= 1'b0;
            end
        end
        err_total++;
        conclude();
    endtask : wr

    // One AXI4-Lite read; data land in v and the response code in r.
    task automatic rd(input logic [11:0] a);
        logic ah;
        ah = 1'b1;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (!ah && rvalid) begin
                v = rdata;
                r = rresp;
                rready <= 1'b0;
                @(posedge aclk);
                return;
            end
            if (ah && arready) begin
                ah = 1'b0;
                arvalid <= 1'b0;
            end
        end
        err_total++;
        conclude();
    endtask : rd

    // Gives every pin and internal source n slow rising edges.
    task automatic tick(input int n);
        repeat (n) begin
            pins <= 4'hf;
            src <= 5'h1f;
            repeat (5) @(posedge aclk);
            pins <= 4'h0;
            src <= 5'h00;
            repeat (5) @(posedge aclk);
        end
    endtask : tick

    // Main sequence: reset, then register and counting scenarios.
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, pins, src, pbd, cap} = '0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(ADDR_CNT_A); chk("count a reset", 32'h0, v);
        rd(12'h020); chk("read unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
        wr(12'h024, 8'h11); chk("write unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
        wr(ADDR_CFG_ONE, 8'h10);
        wr(ADDR_CNT_A, 8'hc8);
        wr(ADDR_CNT_B, 8'h02);
        wr(ADDR_RUN, 8'h03);
        tick(4);
        rd(ADDR_CNT_A); chk("count a up", 32'h3, v);
        rd(ADDR_CNT_B); chk("count b down", 32'h2, v);
        chk("irq b pulses", 32'h1, irq_n[1]);
        wr(ADDR_RUN, 8'h00);
        tick(3);
        rd(ADDR_CNT_A); chk("count a frozen", 32'h3, v);
        wr(ADDR_CNT_A, 8'h0a);
        rd(ADDR_CNT_A); chk("clear deferred", 32'h3, v);
        wr(ADDR_RUN, 8'h01);
        tick(1);
        rd(ADDR_CNT_A); chk("count a cleared", 32'h0, v);
        wr(ADDR_RUN, 8'h00);
        wr(ADDR_CFG_ONE, 8'h11);
        wr(ADDR_CNT_A, 8'h05);
        wr(ADDR_RUN, 8'h01);
        tick(2);
        rd(ADDR_CNT_A); chk("pulse mode write", 32'h2, v);
        chk("pulse pin a", 32'h1, {31'h0, pb0});
        wr(ADDR_RUN, 8'h00);
        wr(ADDR_CFG_ONE, 8'h10);
        wr(ADDR_RUN, 8'h01);
        tick(1);
        rd(ADDR_CNT_A); chk("mode change", 32'h3, v);
        pbd <= 2'b11;
        repeat (3) @(posedge aclk);
        chk("port b pins", 32'h3, {30'h0, pb1, pb0});
        wr(ADDR_RUN, 8'h00);
        wr(ADDR_CLK_SEL, 8'h30);
        wr(ADDR_RUN, 8'h04);
        tick(3);
        chk("irq c on code 11", 32'h3, irq_n[2]);
        chk("irq a silent", 32'h0, irq_n[0]);
        // Halving on the fourth pin clock: four pin edges give two ticks.
        wr(ADDR_RUN, 8'h80);
        wr(ADDR_RUN, 8'h88);
        tick(4);
        chk("irq d halved", 32'h2, irq_n[3]);
        // Joined first pair counting down from 0100: the borrow reaches the high byte.
        wr(ADDR_RUN, 8'h00);
        wr(ADDR_CFG_ONE, 8'h24);
        wr(ADDR_CNT_A, 8'h00);
        wr(ADDR_CNT_B, 8'h01);
        wr(ADDR_RUN, 8'h01);
        tick(2);
        rd(ADDR_CNT_A); chk("joined low byte", 32'hff, v);
        rd(ADDR_CNT_B); chk("joined high byte", 32'h0, v);
        // Capture on rising edges: reads return the shadows, which load on the edge.
        wr(ADDR_RUN, 8'h00);
        wr(ADDR_CFG_TWO, 8'h10);
        rd(ADDR_CNT_A); chk("shadow before capture", 32'h0, v);
        cap <= 1'b1;
        repeat (6) @(posedge aclk);
        rd(ADDR_CNT_A); chk("captured low", 32'hff, v);
        chk("capture irq a", 32'h1, irq_n[0]);
        chk("capture irq b", 32'h2, irq_n[1]);
        conclude();
    end
endmodule : test_qcm_quad_counter
